// ==== rtl/uswc_pkg.sv ====
// package: register map, field positions and carrier types for the serial wire clock control
package uswc_pkg;

	localparam logic [1:0] ADDR_CTRL   = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA   = 2'h2;
	localparam logic [1:0] ADDR_PORT   = 2'h3;

	// control register fields
	localparam int CTRL_WM_HI   = 5;
	localparam int CTRL_WM_LO   = 4;
	localparam int CTRL_CS_HI   = 3;
	localparam int CTRL_CS_LO   = 2;
	localparam int CTRL_STROBE  = 1;
	localparam int CTRL_TOGGLE  = 0;

	// status register fields
	localparam int STAT_START   = 7;
	localparam int STAT_WRAP    = 6;
	localparam int STAT_CNT_HI  = 3;

	// port register fields
	localparam int PORT_DO_OUT  = 0;
	localparam int PORT_DO_DIR  = 1;
	localparam int PORT_DI_OUT  = 2;
	localparam int PORT_DI_DIR  = 3;
	localparam int PORT_CK_OUT  = 4;
	localparam int PORT_CK_DIR  = 5;

	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [3:0] CNT_MAX     = 4'hF;
	localparam logic [3:0] CNT_ONE     = 4'h1;

	typedef enum logic [1:0]
	{
		WM_OFF   = 2'b00,
		WM_THREE = 2'b01,
		WM_TWO   = 2'b10,
		WM_TWO_H = 2'b11
	} uswc_wire_type;

	typedef enum logic [1:0]
	{
		CS_SOFT  = 2'b00,
		CS_TIMER = 2'b01,
		CS_EXT_R = 2'b10,
		CS_EXT_F = 2'b11
	} uswc_src_type;

	typedef struct packed
	{
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} uswc_bus_type;

	// one pin: level out, enable, pull-up request
	typedef struct packed
	{
		logic o;
		logic oe;
		logic pu;
	} uswc_pin_type;

endpackage

// ==== rtl/uswc_sync.sv ====
// two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module uswc_sync
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// meta_q feeds only sync_q
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			// lines idle high on their pull-ups; resetting to that level avoids a false edge
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end
		else
		begin
			meta_q <= pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise  = sync_q & ~prev_q;
	assign fall  = ~sync_q & prev_q;
endmodule // uswc_sync

// ==== rtl/uswc_ctrl.sv ====
// serial wire mode and clock source control with shift register and 4-bit counter
`timescale 1ns/1ps
module uswc_ctrl
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire uswc_pkg::uswc_bus_type bus,
	output logic [7:0]                 rdata,
	input  wire logic                  timer_match,
	input  wire logic                  do_in,
	input  wire logic                  di_in,
	input  wire logic                  ck_in,
	output uswc_pkg::uswc_pin_type     do_pin,
	output uswc_pkg::uswc_pin_type     di_pin,
	output uswc_pkg::uswc_pin_type     ck_pin
);
	logic [5:2] ctrl_q;
	logic [7:0] data_q;
	logic [3:0] cnt_q;
	logic       start_q;
	logic       wrap_q;
	logic [5:0] port_q;
	logic       latch_q;
	logic [7:0] rdata_q;
	logic       di_prev_q;
	uswc_pkg::uswc_pin_type do_q;
	uswc_pkg::uswc_pin_type di_q;
	uswc_pkg::uswc_pin_type ck_q;

	logic di_s;
	logic di_fall;
	logic ck_s;
	logic ck_rise;
	logic ck_fall;

	// pins reach logic only through synchronisers
	uswc_sync u_ck
	(
		.clk   (clk),
		.rst   (rst),
		.pin   (ck_in),
		.level (ck_s),
		.rise  (ck_rise),
		.fall  (ck_fall)
	);

	uswc_sync u_di
	(
		.clk   (clk),
		.rst   (rst),
		.pin   (di_in),
		.level (di_s),
		.rise  (),
		.fall  (di_fall)
	);

	function automatic logic wr_at(input uswc_pkg::uswc_bus_type b, input logic [1:0] a);
		wr_at = b.wr && (b.addr == a);
	endfunction

	uswc_pkg::uswc_wire_type wm;
	uswc_pkg::uswc_src_type  cs;
	logic two_wire;
	logic sw_strobe;
	logic tg_strobe;
	logic shift_en;
	logic count_en;
	logic ext_sel;
	logic ctrl_wr;

	assign wm       = uswc_pkg::uswc_wire_type'(ctrl_q[uswc_pkg::CTRL_WM_HI:uswc_pkg::CTRL_WM_LO]);
	assign cs       = uswc_pkg::uswc_src_type'(ctrl_q[uswc_pkg::CTRL_CS_HI:uswc_pkg::CTRL_CS_LO]);
	assign two_wire = wm[1];
	assign ext_sel  = cs[1];
	assign ctrl_wr  = wr_at(bus, uswc_pkg::ADDR_CTRL);
	// strobes act under the configuration already stored, not the one written with them
	assign sw_strobe = ctrl_wr && bus.wdata[uswc_pkg::CTRL_STROBE];
	assign tg_strobe = ctrl_wr && bus.wdata[uswc_pkg::CTRL_TOGGLE];

	logic strobe_sel_q;

	always_comb
	begin
		shift_en = 1'b0;
		count_en = 1'b0;
		unique case (cs)
			uswc_pkg::CS_SOFT:
			begin
				shift_en = sw_strobe;
				count_en = sw_strobe;
			end
			uswc_pkg::CS_TIMER:
			begin
				shift_en = timer_match;
				count_en = timer_match;
			end
			uswc_pkg::CS_EXT_R:
			begin
				shift_en = ck_rise;
				count_en = strobe_sel_q ? tg_strobe : (ck_rise | ck_fall);
			end
			uswc_pkg::CS_EXT_F:
			begin
				shift_en = ck_fall;
				count_en = strobe_sel_q ? tg_strobe : (ck_rise | ck_fall);
			end
		endcase
	end

	// control register; the strobe bit is also stored as the strobe-select bit, the toggle bit is not stored
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl_q       <= '0;
			strobe_sel_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			ctrl_q       <= bus.wdata[uswc_pkg::CTRL_WM_HI:uswc_pkg::CTRL_CS_LO];
			strobe_sel_q <= bus.wdata[uswc_pkg::CTRL_STROBE];
		end
	end

	// input sampled every cycle so a strobe shifts in the previous cycle's value
	always_ff @(posedge clk)
	begin
		if (rst)
			di_prev_q <= 1'b0;
		else
			di_prev_q <= di_s;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			data_q <= uswc_pkg::RESET_BYTE;
		else if (wr_at(bus, uswc_pkg::ADDR_DATA))
			data_q <= bus.wdata;
		else if (shift_en)
			data_q <= {data_q[6:0], (ext_sel ? di_s : di_prev_q)};
	end

	// output latch: follows the top bit on the edge opposite to sampling
	always_ff @(posedge clk)
	begin
		if (rst)
			latch_q <= 1'b0;
		else if (!ext_sel)
			latch_q <= data_q[7]; // tracked while transparent: no jump on a source change
		else if ((cs == uswc_pkg::CS_EXT_R) ? ck_fall : ck_rise)
			latch_q <= data_q[7];
	end

	logic serial_out;
	assign serial_out = ext_sel ? latch_q : data_q[7];

	always_ff @(posedge clk)
	begin
		if (rst)
			cnt_q <= '0;
		else if (wr_at(bus, uswc_pkg::ADDR_STATUS))
			cnt_q <= bus.wdata[uswc_pkg::STAT_CNT_HI:0];
		else if (count_en)
			cnt_q <= cnt_q + uswc_pkg::CNT_ONE;
	end

	// start set wins over a clear in the same cycle; a status write blocks the wrap set
	logic wrap_evt;
	logic start_evt;
	logic stat_wr;
	assign wrap_evt  = count_en && (cnt_q == uswc_pkg::CNT_MAX) && !wr_at(bus, uswc_pkg::ADDR_STATUS);
	// start: data falls while clock high, detector off in modes 00 and 01
	assign start_evt = two_wire && di_fall && ck_s;
	assign stat_wr   = wr_at(bus, uswc_pkg::ADDR_STATUS);

	always_ff @(posedge clk)
	begin
		if (rst)
			wrap_q <= 1'b0;
		else if (wrap_evt)
			wrap_q <= 1'b1;
		else if (stat_wr && bus.wdata[uswc_pkg::STAT_WRAP])
			wrap_q <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			start_q <= 1'b0;
		else if (start_evt)
			start_q <= 1'b1;
		else if (stat_wr && bus.wdata[uswc_pkg::STAT_START])
			start_q <= 1'b0;
	end

	// port bits; toggle inverts clock port bit whatever the direction
	always_ff @(posedge clk)
	begin
		if (rst)
			port_q <= '0;
		else if (wr_at(bus, uswc_pkg::ADDR_PORT))
			port_q <= bus.wdata[5:0];
		else if (tg_strobe)
			port_q[uswc_pkg::PORT_CK_OUT] <= ~port_q[uswc_pkg::PORT_CK_OUT];
	end

	logic ck_hold;
	assign ck_hold = two_wire && (start_q || (wm == uswc_pkg::WM_TWO_H && wrap_q));

	// pin drive; open-drain pins only ever drive low
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			do_q <= '0;
			di_q <= '0;
			ck_q <= '0;
		end
		else
		begin
			do_q.o  <= port_q[uswc_pkg::PORT_DO_OUT];
			do_q.oe <= port_q[uswc_pkg::PORT_DO_DIR];
			do_q.pu <= !port_q[uswc_pkg::PORT_DO_DIR] && port_q[uswc_pkg::PORT_DO_OUT];
			di_q.o  <= port_q[uswc_pkg::PORT_DI_OUT];
			di_q.oe <= port_q[uswc_pkg::PORT_DI_DIR];
			di_q.pu <= !port_q[uswc_pkg::PORT_DI_DIR] && port_q[uswc_pkg::PORT_DI_OUT];
			ck_q.o  <= port_q[uswc_pkg::PORT_CK_OUT];
			ck_q.oe <= port_q[uswc_pkg::PORT_CK_DIR];
			ck_q.pu <= !port_q[uswc_pkg::PORT_CK_DIR] && port_q[uswc_pkg::PORT_CK_OUT];
			unique case (wm)
				uswc_pkg::WM_OFF:
					;
				uswc_pkg::WM_THREE:
					do_q.o <= serial_out;
				uswc_pkg::WM_TWO, uswc_pkg::WM_TWO_H:
				begin
					di_q.o  <= 1'b0;
					di_q.oe <= port_q[uswc_pkg::PORT_DI_DIR] &&
						!(serial_out && port_q[uswc_pkg::PORT_DI_OUT]);
					di_q.pu <= 1'b0;
					ck_q.o  <= 1'b0;
					ck_q.oe <= port_q[uswc_pkg::PORT_CK_DIR] &&
						(!port_q[uswc_pkg::PORT_CK_OUT] || ck_hold);
					ck_q.pu <= 1'b0;
				end
			endcase
		end
	end

	assign do_pin = do_q;
	assign di_pin = di_q;
	assign ck_pin = ck_q;

	// read data one cycle after the strobe; strobe and toggle bits read zero
	always_ff @(posedge clk)
	begin
		if (rst)
			rdata_q <= '0;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				uswc_pkg::ADDR_CTRL:
					rdata_q <= {2'h0, ctrl_q, 2'h0};
				uswc_pkg::ADDR_STATUS:
					rdata_q <= {start_q, wrap_q, 2'h0, cnt_q};
				uswc_pkg::ADDR_DATA:
					rdata_q <= data_q;
				uswc_pkg::ADDR_PORT:
					rdata_q <= {1'b0, ck_s, port_q};
			endcase
		end
		else
			rdata_q <= '0;
	end

	assign rdata = rdata_q;
endmodule // uswc_ctrl

// ==== sim/uswc_monitor.sv ====
// checker: pin relations and strobe read-back of the serial wire control
`timescale 1ns/1ps
module uswc_monitor
(
	input wire logic                   clk,
	input wire logic                   rst,
	input wire uswc_pkg::uswc_bus_type bus,
	input wire logic [7:0]             rdata,
	input wire uswc_pkg::uswc_pin_type do_pin,
	input wire uswc_pkg::uswc_pin_type di_pin,
	input wire uswc_pkg::uswc_pin_type ck_pin
);
	logic [1:0] wm_q;
	logic [7:0] pt_q;
	logic [1:0] age_q;
	logic       s;
	logic       m3;
	// pins lag a write by two cycles, so relations are only judged once settled
	assign s = age_q[1];
	assign m3 = wm_q == 2'h1;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wm_q <= 2'h0;
			pt_q <= 8'h00;
		end
		else if (bus.wr && bus.addr == 2'h0)
		begin
			wm_q    <= bus.wdata[5:4];
			pt_q[4] <= pt_q[4] ^ bus.wdata[0];
		end
		else if (bus.wr && bus.addr == 2'h3)
			pt_q <= bus.wdata;
	end
	always_ff @(posedge clk)
	begin
		if (rst || bus.wr)
			age_q <= 2'h0;
		else if (!age_q[1])
			age_q <= age_q + 2'h1;
	end
	a_two_pull_off: assert property (s && wm_q[1] |-> !di_pin.pu && !ck_pin.pu)
		else $error("pull-up on in two-wire mode");
	a_two_ck_dir: assert property (s && wm_q[1] && !pt_q[5] |-> !ck_pin.oe)
		else $error("clock driven without direction");
	a_two_ck_low: assert property (s && wm_q[1] && pt_q[5] && !pt_q[4] |-> ck_pin.oe)
		else $error("clock not pulled low");
	a_two_da_low: assert property (s && wm_q[1] && pt_q[3] && !pt_q[2] |-> di_pin.oe)
		else $error("data not pulled low");
	a_three_do_dir: assert property (s && m3 |-> do_pin.oe == pt_q[1])
		else $error("data out enable wrong");
	a_three_do_pull: assert property (s && m3 && !pt_q[1] |-> do_pin.pu == pt_q[0])
		else $error("data out pull-up wrong");
	a_three_ck_port: assert property
		(s && m3 |-> ck_pin.o == pt_q[4] && ck_pin.oe == pt_q[5] && di_pin.o == pt_q[2])
		else $error("clock or data-in pin not port driven");
	a_off_port_pins: assert property
		(s && wm_q == 2'h0 |-> do_pin.o == pt_q[0] && di_pin.o == pt_q[2] && ck_pin.oe == pt_q[5])
		else $error("pins not port driven with outputs disabled");
	a_strobe_zero: assert property
		(bus.rd && bus.addr == 2'h0 |=> rdata[1:0] == 2'h0)
		else $error("strobe bits read back set");
endmodule // uswc_monitor

bind uswc_ctrl uswc_monitor i_mon
(
	.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
	.do_pin(do_pin), .di_pin(di_pin), .ck_pin(ck_pin)
);

// ==== sim/uswc_peer.sv ====
// partner: serial peer that frames clock pulses and start conditions
`timescale 1ns/1ps
module uswc_peer
(
	output logic sda_lo,
	output logic scl_lo
);
	// lines idle released to the pull-up; the clock stands still between frames
	initial
	begin
		sda_lo = 1'b0;
		scl_lo = 1'b0;
	end
	task automatic send(input logic [3:0] bits);
		for (int i = 3; i >= 0; i--)
		begin
			sda_lo = !bits[i];
			#40 scl_lo = 1'b1;
			#80 scl_lo = 1'b0;
			#40;
		end
		sda_lo = 1'b0;
	endtask
	task automatic start_cond();
		#40 sda_lo = 1'b1;
		#80 scl_lo = 1'b1;
		#80 sda_lo = 1'b0;
		#80 scl_lo = 1'b0;
	endtask
endmodule // uswc_peer

// ==== sim/tb_top.sv ====
// testbench: register rows, clock sources, wire modes and line holds
`timescale 1ns/1ps
module tb_top;
	logic                   clk, rst, timer_match, sda_lo, scl_lo;
	logic [7:0]             rdata, q;
	logic [23:0]            rows [5];
	uswc_pkg::uswc_bus_type bus;
	uswc_pkg::uswc_pin_type do_pin, di_pin, ck_pin;
	int                     n_errors, tests_run, cycles;
	// open-drain lines: low if any party pulls them, else the pull-up wins
	wire                    sda = !(sda_lo || (di_pin.oe && !di_pin.o));
	wire                    scl = !(scl_lo || (ck_pin.oe && !ck_pin.o));
	uswc_ctrl i_dut
	(
		.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .timer_match(timer_match),
		.do_in(1'b0), .di_in(sda), .ck_in(scl),
		.do_pin(do_pin), .di_pin(di_pin), .ck_pin(ck_pin)
	);
	uswc_peer i_peer
	(
		.sda_lo(sda_lo), .scl_lo(scl_lo)
	);
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk);
			timer_match <= 1'b1;
			@(posedge clk);
			timer_match <= 1'b0;
		end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		timer_match = 1'b0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		rows = '{24'h001310, 24'h02A5A5, 24'h010E0E, 24'h031D5D, 24'h001C1C};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++)
		begin
			rd(a[1:0], q);
			chk(q, a == 3 ? 8'h40 : 8'h00);
		end
		foreach (rows[i])
		begin
			wr(rows[i][17:16], rows[i][15:8]);
			rd(rows[i][17:16], q);
			chk(q, rows[i][7:0]);
		end
		wr(2'h3, 8'h1F);
		wr(2'h0, 8'h10);
		wr(2'h2, 8'h80);
		wr(2'h1, 8'h00);
		idle(3);
		chk({7'h00, do_pin.o}, 8'h01);
		wr(2'h0, 8'h12);
		idle(3);
		chk({7'h00, do_pin.o}, 8'h00);
		rd(2'h2, q);
		chk(q, 8'h01);
		rd(2'h1, q);
		chk(q, 8'h01);
		wr(2'h1, 8'h0F);
		wr(2'h0, 8'h12);
		rd(2'h1, q);
		chk(q, 8'h40);
		wr(2'h1, 8'h00);
		rd(2'h1, q);
		chk(q, 8'h40);
		wr(2'h1, 8'h40);
		rd(2'h1, q);
		chk(q, 8'h00);
		wr(2'h0, 8'h14);
		tick(3);
		wr(2'h0, 8'h10);
		tick(2);
		rd(2'h1, q);
		chk(q, 8'h03);
		wr(2'h3, 8'h00);
		for (int k = 2; k < 4; k++)
		begin
			wr(2'h0, {4'h1, k[1:0], 2'h0});
			wr(2'h2, 8'h00);
			wr(2'h1, 8'h00);
			#3 i_peer.send(4'hB);
			idle(8);
			rd(2'h2, q);
			chk(q, 8'h0B);
			rd(2'h1, q);
			chk(q, 8'h08);
		end
		wr(2'h0, 8'h18);
		wr(2'h3, 8'h30);
		wr(2'h2, 8'h80);
		idle(3);
		chk({7'h00, do_pin.o}, 8'h00);
		wr(2'h0, 8'h19);
		idle(6);
		chk({7'h00, do_pin.o}, 8'h01);
		wr(2'h0, 8'h1A);
		wr(2'h1, 8'h00);
		repeat (3) wr(2'h0, 8'h1B);
		rd(2'h1, q);
		chk(q, 8'h03);
		rd(2'h3, q);
		chk(q & 8'h10, 8'h10);
		wr(2'h0, 8'h20);
		wr(2'h2, 8'hFF);
		wr(2'h3, 8'h1C);
		idle(4);
		wr(2'h3, 8'h28);
		idle(4);
		wr(2'h3, 8'h3C);
		wr(2'h1, 8'hC0);
		#3 i_peer.start_cond();
		idle(4);
		rd(2'h1, q);
		chk(q & 8'h80, 8'h80);
		chk({7'h00, ck_pin.oe}, 8'h01);
		wr(2'h1, 8'h80);
		idle(3);
		chk({7'h00, ck_pin.oe}, 8'h00);
		wr(2'h1, 8'h0F);
		wr(2'h0, 8'h32);
		idle(3);
		chk({7'h00, ck_pin.oe}, 8'h01);
		wr(2'h1, 8'h40);
		idle(3);
		chk({7'h00, ck_pin.oe}, 8'h00);
		wrap_up();
	end
endmodule // tb_top
